// ---- logic/asdt_pkg.sv ----
package asdt_pkg;

  typedef enum logic [2:0] {
    ASDT_W_BYTE  = 3'h1,
    ASDT_W_WORD  = 3'h2,
    ASDT_W_DWORD = 3'h4
  } asdt_width_t;

  typedef enum logic [4:0] {
    ASDT_C_NONE     = 5'h00,
    ASDT_C_CMP_IMM  = 5'h01,
    ASDT_C_CMP_ACC  = 5'h02,
    ASDT_C_NEG      = 5'h03,
    ASDT_C_AAA      = 5'h04,
    ASDT_C_AAS      = 5'h05,
    ASDT_C_DAA      = 5'h06,
    ASDT_C_DAS      = 5'h07,
    ASDT_C_MUL      = 5'h08,
    ASDT_C_SIGNED_PRODUCT_ACC = 5'h09,
    ASDT_C_SIGNED_PRODUCT_REG = 5'h0A,
    ASDT_C_SIGNED_PRODUCT_IMM = 5'h0B,
    ASDT_C_DIV      = 5'h0C,
    ASDT_C_SIGNED_QUOTIENT     = 5'h0D,
    ASDT_C_AAD      = 5'h0E,
    ASDT_C_AAM      = 5'h0F,
    ASDT_C_CBW      = 5'h10,
    ASDT_C_CWD      = 5'h11,
    ASDT_C_SHIFT    = 5'h12,
    ASDT_C_DOUBLE_SHIFT_LEFT     = 5'h13,
    ASDT_C_DOUBLE_SHIFT_RIGHT     = 5'h14
  } asdt_class_t;

  typedef struct packed {
    logic        esc;
    logic [7:0]  opcode;
    logic [7:0]  modrm;
    logic        size32;
    logic [4:0]  mul_extra;
  } asdt_req_t;

  typedef struct packed {
    asdt_class_t op_class;
    asdt_width_t width;
    logic [2:0]  shift_kind;
    logic        mem_op;
    logic [5:0]  clocks;
    logic [1:0]  data_cycles;
    logic        illegal;
  } asdt_res_t;

  localparam logic [1:0] MOD_REG     = 2'h3;
  localparam logic [5:0] OPC_GRP1_HI = 6'h20;
  localparam logic [6:0] OPC_CMPA_HI = 7'h1E;
  localparam logic [6:0] OPC_GRP3_HI = 7'h7B;
  localparam logic [6:0] OPC_SH1_HI  = 7'h68;
  localparam logic [6:0] OPC_SHC_HI  = 7'h69;
  localparam logic [6:0] OPC_SHI_HI  = 7'h60;
  localparam logic [5:0] OPC_IMULI_HI = 6'h1A;
  localparam logic [7:0] OPC_AAA = 8'h37;
  localparam logic [7:0] OPC_AAS = 8'h3F;
  localparam logic [7:0] OPC_DAA = 8'h27;
  localparam logic [7:0] OPC_DAS = 8'h2F;
  localparam logic [7:0] OPC_AAD = 8'hD5;
  localparam logic [7:0] OPC_AAM = 8'hD4;
  localparam logic [7:0] OPC_AAX_TAIL = 8'h0A;
  localparam logic [7:0] OPC_CBW = 8'h98;
  localparam logic [7:0] OPC_CWD = 8'h99;
  localparam logic [7:0] ESC_SIGNED_PRODUCT   = 8'hAF;
  localparam logic [7:0] ESC_DOUBLE_SHIFT_LEFT_I = 8'hA4;
  localparam logic [7:0] ESC_DOUBLE_SHIFT_LEFT_C = 8'hA5;
  localparam logic [7:0] ESC_DOUBLE_SHIFT_RIGHT_I = 8'hAC;
  localparam logic [7:0] ESC_DOUBLE_SHIFT_RIGHT_C = 8'hAD;
  localparam logic [2:0] FLD_CMP  = 3'h7;
  localparam logic [2:0] FLD_NEG  = 3'h3;
  localparam logic [2:0] FLD_MUL  = 3'h4;
  localparam logic [2:0] FLD_SIGNED_PRODUCT = 3'h5;
  localparam logic [2:0] FLD_DIV  = 3'h6;
  localparam logic [2:0] FLD_SIGNED_QUOTIENT = 3'h7;
  localparam logic [2:0] SK_ROL = 3'h0;
  localparam logic [2:0] SK_ROR = 3'h1;
  localparam logic [2:0] SK_RCL = 3'h2;
  localparam logic [2:0] SK_RCR = 3'h3;
  localparam logic [2:0] SK_SHL = 3'h4;
  localparam logic [2:0] SK_SHR = 3'h5;
  localparam logic [2:0] SK_SAR = 3'h7;
  localparam logic [5:0] CLK_CMP_R = 6'h02;
  localparam logic [5:0] CLK_CMP_M = 6'h05;
  localparam logic [5:0] CLK_CMPA  = 6'h02;
  localparam logic [5:0] CLK_NEG_R = 6'h02;
  localparam logic [5:0] CLK_NEG_M = 6'h06;
  localparam logic [5:0] CLK_FIX   = 6'h04;
  localparam logic [5:0] CLK_MUL_R = 6'h0C;
  localparam logic [5:0] CLK_IMULI_R = 6'h0D;
  localparam logic [5:0] CLK_MUL_MB  = 6'h0F;
  localparam logic [5:0] CLK_MUL_MW  = 6'h0F;
  localparam logic [5:0] CLK_MUL_MD  = 6'h11;
  localparam logic [5:0] CLK_IMULI_MW = 6'h0E;
  localparam logic [5:0] CLK_IMULI_MD = 6'h10;
  localparam logic [5:0] SPAN_B = 6'h05;
  localparam logic [5:0] SPAN_W = 6'h0D;
  localparam logic [5:0] SPAN_D = 6'h1D;
  localparam logic [5:0] CLK_DIV_B_R = 6'h0E;
  localparam logic [5:0] CLK_DIV_B_M = 6'h11;
  localparam logic [5:0] CLK_DIV_W_R = 6'h16;
  localparam logic [5:0] CLK_DIV_W_M = 6'h19;
  localparam logic [5:0] CLK_DIV_D_R = 6'h26;
  localparam logic [5:0] CLK_DIV_D_M = 6'h2B;
  localparam logic [5:0] CLK_SIGNED_QUOTIENT_B_R = 6'h13;
  localparam logic [5:0] CLK_SIGNED_QUOTIENT_B_M = 6'h16;
  localparam logic [5:0] CLK_SIGNED_QUOTIENT_W_R = 6'h1B;
  localparam logic [5:0] CLK_SIGNED_QUOTIENT_W_M = 6'h1E;
  localparam logic [5:0] CLK_SIGNED_QUOTIENT_D_R = 6'h2B;
  localparam logic [5:0] CLK_SIGNED_QUOTIENT_D_M = 6'h30;
  localparam logic [5:0] CLK_AAD = 6'h13;
  localparam logic [5:0] CLK_AAM = 6'h11;
  localparam logic [5:0] CLK_CBW = 6'h03;
  localparam logic [5:0] CLK_CWD = 6'h02;
  localparam logic [5:0] CLK_SH_R  = 6'h03;
  localparam logic [5:0] CLK_SH_M  = 6'h07;
  localparam logic [5:0] CLK_RC_R  = 6'h09;
  localparam logic [5:0] CLK_RC_M  = 6'h0A;
  localparam logic [5:0] CLK_ILLEGAL = 6'h01;
  localparam logic [1:0] DC_NONE = 2'h0;
  localparam logic [1:0] DC_ONE  = 2'h1;
  localparam logic [1:0] DC_TWO  = 2'h2;
  localparam logic [5:0] COUNT_RST = 6'h00;

endpackage

// ---- logic/asdt_core.sv ----
// How it works
// [RULE_01] Compare-immediate group 100000sw, field 111: 2 clocks register, 5 memory.
// [RULE_02] Short accumulator compare with immediate completes in 2 clocks.
// [RULE_03] Sign change 1111011w field 011: 2 register, 6 memory, two data cycles.
// [RULE_04] ASCII and BCD fix opcodes each take 4 clocks, no data cycles.
// [RULE_05] Unsigned product field 100: variable clocks per width, memory longer.
// [RULE_06] Accumulator signed product field 101 uses the unsigned product ranges.
// [RULE_07] Two-operand signed product: escape plus 10101111, same ranges.
// [RULE_08] Immediate signed product 011010s1: 13-26 word, 13-42 dword, memory longer.
// [RULE_09] Unsigned quotient field 110: byte 14/17, word 22/25, dword 38/43.
// [RULE_10] Signed quotient field 111: byte 19/22, word 27/30, dword 43/48.
// [RULE_11] Divide fix D5 0A takes 19 clocks; product fix D4 0A takes 17.
// [RULE_12] Byte-to-word extend 3 clocks; word-to-dword extend 2 clocks.
// [RULE_13] Shift kind field picks rotate, carry rotate, or shift operation.
// [RULE_14] Non-carry shifts by one, count register or immediate: 3/7 clocks.
// [RULE_15] Carry rotates use same forms, 9 clocks register, 10 memory.
// [RULE_16] Double shift left A4/A5 after escape: 3 register, 7 memory.
// [RULE_17] Double shift right AC/AD after escape: 3 register, 7 memory.
// [RULE_18] Opcode bit w clear means byte operand, set means full width.
`timescale 1ns/1ps
module asdt_core (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              dec_valid_i,
  input  wire asdt_pkg::asdt_req_t dec_in_i,
  output logic                   idle_o,
  output logic                   busy_o,
  output logic                   done_o,
  output asdt_pkg::asdt_res_t    dec_out_o
);

  typedef enum logic [1:0] {
    ASDT_S_IDLE = 2'b01,
    ASDT_S_EXEC = 2'b10
  } asdt_state_t;

  typedef struct packed {
    asdt_state_t         fsm;
    logic [5:0]          count;
    asdt_pkg::asdt_res_t res;
    logic                idle;
    logic                busy;
    logic                done;
  } asdt_regs_t;

  asdt_regs_t st_reg;
  asdt_regs_t st_next;

  function automatic logic [1:0] mem_cycles(input logic mem, input asdt_pkg::asdt_width_t wd);
    if (!mem)
      return asdt_pkg::DC_NONE;
    return (wd == asdt_pkg::ASDT_W_DWORD) ? asdt_pkg::DC_TWO : asdt_pkg::DC_ONE;
  endfunction

  // Early-out of the multiplier is modelled by mul_extra, clamped to the span
  function automatic logic [5:0] mul_clocks(input logic mem, input asdt_pkg::asdt_width_t wd,
                                            input logic imm_form, input logic [4:0] extra);
    logic [5:0] base;
    logic [5:0] span;
    logic [5:0] ext;
    base = imm_form ? asdt_pkg::CLK_IMULI_R : asdt_pkg::CLK_MUL_R;
    span = asdt_pkg::SPAN_D;
    ext  = {1'b0, extra};
    case (wd)
      asdt_pkg::ASDT_W_BYTE: begin
        span = asdt_pkg::SPAN_B;
        if (mem)
          base = asdt_pkg::CLK_MUL_MB;
      end
      asdt_pkg::ASDT_W_WORD: begin
        span = asdt_pkg::SPAN_W;
        if (mem)
          base = imm_form ? asdt_pkg::CLK_IMULI_MW : asdt_pkg::CLK_MUL_MW;
      end
      default: begin
        span = asdt_pkg::SPAN_D;
        if (mem)
          base = imm_form ? asdt_pkg::CLK_IMULI_MD : asdt_pkg::CLK_MUL_MD;
      end
    endcase
    if (ext > span)
      ext = span;
    return 6'(base + ext);
  endfunction

  function automatic logic [5:0] rm_clocks(input logic mem, input logic [5:0] r, input logic [5:0] m);
    return mem ? m : r;
  endfunction

  function automatic asdt_pkg::asdt_res_t decode(input asdt_pkg::asdt_req_t q);
    asdt_pkg::asdt_res_t r;
    asdt_pkg::asdt_width_t wd;
    logic mem;
    logic [2:0] fld;
    r   = '0;
    mem = (q.modrm[7:6] != asdt_pkg::MOD_REG);
    fld = q.modrm[5:3];
    wd  = !q.opcode[0] ? asdt_pkg::ASDT_W_BYTE :
          (q.size32 ? asdt_pkg::ASDT_W_DWORD : asdt_pkg::ASDT_W_WORD); // [RULE_18]
    r.op_class    = asdt_pkg::ASDT_C_NONE;
    r.width       = wd;
    r.clocks      = asdt_pkg::CLK_ILLEGAL;
    r.data_cycles = asdt_pkg::DC_NONE;
    r.illegal     = 1'b1;
    if (q.esc) begin
      r.width  = q.size32 ? asdt_pkg::ASDT_W_DWORD : asdt_pkg::ASDT_W_WORD;
      r.mem_op = mem;
      case (q.opcode)
        asdt_pkg::ESC_SIGNED_PRODUCT: begin
          r.op_class    = asdt_pkg::ASDT_C_SIGNED_PRODUCT_REG; // [RULE_07]
          r.clocks      = mul_clocks(mem, r.width, 1'b0, q.mul_extra);
          r.data_cycles = mem_cycles(mem, r.width);
          r.illegal     = 1'b0;
        end
        asdt_pkg::ESC_DOUBLE_SHIFT_LEFT_I, asdt_pkg::ESC_DOUBLE_SHIFT_LEFT_C: begin
          r.op_class    = asdt_pkg::ASDT_C_DOUBLE_SHIFT_LEFT; // [RULE_16]
          r.clocks      = rm_clocks(mem, asdt_pkg::CLK_SH_R, asdt_pkg::CLK_SH_M);
          r.data_cycles = mem ? asdt_pkg::DC_TWO : asdt_pkg::DC_NONE;
          r.illegal     = 1'b0;
        end
        asdt_pkg::ESC_DOUBLE_SHIFT_RIGHT_I, asdt_pkg::ESC_DOUBLE_SHIFT_RIGHT_C: begin
          r.op_class    = asdt_pkg::ASDT_C_DOUBLE_SHIFT_RIGHT; // [RULE_17]
          r.clocks      = rm_clocks(mem, asdt_pkg::CLK_SH_R, asdt_pkg::CLK_SH_M);
          r.data_cycles = mem ? asdt_pkg::DC_TWO : asdt_pkg::DC_NONE;
          r.illegal     = 1'b0;
        end
        default: r.mem_op = 1'b0;
      endcase
    end else if (q.opcode[7:2] == asdt_pkg::OPC_GRP1_HI) begin
      // Other group fields belong to neighbouring arithmetic logic
      if (fld == asdt_pkg::FLD_CMP) begin
        r.op_class    = asdt_pkg::ASDT_C_CMP_IMM; // [RULE_01]
        r.mem_op      = mem;
        r.clocks      = rm_clocks(mem, asdt_pkg::CLK_CMP_R, asdt_pkg::CLK_CMP_M);
        r.data_cycles = mem ? asdt_pkg::DC_ONE : asdt_pkg::DC_NONE;
        r.illegal     = 1'b0;
      end
    end else if (q.opcode[7:1] == asdt_pkg::OPC_CMPA_HI) begin
      r.op_class = asdt_pkg::ASDT_C_CMP_ACC; // [RULE_02]
      r.clocks   = asdt_pkg::CLK_CMPA;
      r.illegal  = 1'b0;
    end else if (q.opcode[7:1] == asdt_pkg::OPC_GRP3_HI) begin
      r.mem_op  = mem;
      r.illegal = 1'b0;
      case (fld)
        asdt_pkg::FLD_NEG: begin
          r.op_class    = asdt_pkg::ASDT_C_NEG; // [RULE_03]
          r.clocks      = rm_clocks(mem, asdt_pkg::CLK_NEG_R, asdt_pkg::CLK_NEG_M);
          r.data_cycles = mem ? asdt_pkg::DC_TWO : asdt_pkg::DC_NONE;
        end
        asdt_pkg::FLD_MUL, asdt_pkg::FLD_SIGNED_PRODUCT: begin
          r.op_class    = (fld == asdt_pkg::FLD_MUL) ? asdt_pkg::ASDT_C_MUL
                                                     : asdt_pkg::ASDT_C_SIGNED_PRODUCT_ACC; // [RULE_05] [RULE_06]
          r.clocks      = mul_clocks(mem, wd, 1'b0, q.mul_extra);
          r.data_cycles = mem_cycles(mem, wd);
        end
        asdt_pkg::FLD_DIV: begin
          r.op_class    = asdt_pkg::ASDT_C_DIV; // [RULE_09]
          r.data_cycles = mem_cycles(mem, wd);
          case (wd)
            asdt_pkg::ASDT_W_BYTE: r.clocks = rm_clocks(mem, asdt_pkg::CLK_DIV_B_R, asdt_pkg::CLK_DIV_B_M);
            asdt_pkg::ASDT_W_WORD: r.clocks = rm_clocks(mem, asdt_pkg::CLK_DIV_W_R, asdt_pkg::CLK_DIV_W_M);
            default:               r.clocks = rm_clocks(mem, asdt_pkg::CLK_DIV_D_R, asdt_pkg::CLK_DIV_D_M);
          endcase
        end
        asdt_pkg::FLD_SIGNED_QUOTIENT: begin
          r.op_class    = asdt_pkg::ASDT_C_SIGNED_QUOTIENT; // [RULE_10]
          r.data_cycles = mem_cycles(mem, wd);
          case (wd)
            asdt_pkg::ASDT_W_BYTE: r.clocks = rm_clocks(mem, asdt_pkg::CLK_SIGNED_QUOTIENT_B_R, asdt_pkg::CLK_SIGNED_QUOTIENT_B_M);
            asdt_pkg::ASDT_W_WORD: r.clocks = rm_clocks(mem, asdt_pkg::CLK_SIGNED_QUOTIENT_W_R, asdt_pkg::CLK_SIGNED_QUOTIENT_W_M);
            default:               r.clocks = rm_clocks(mem, asdt_pkg::CLK_SIGNED_QUOTIENT_D_R, asdt_pkg::CLK_SIGNED_QUOTIENT_D_M);
          endcase
        end
        default: begin
          r.mem_op  = 1'b0;
          r.illegal = 1'b1;
        end
      endcase
    end else if (q.opcode[7:2] == asdt_pkg::OPC_IMULI_HI && q.opcode[0]) begin
      // Bit 1 is the sign-extend flag here, so width is never byte
      r.op_class    = asdt_pkg::ASDT_C_SIGNED_PRODUCT_IMM; // [RULE_08]
      r.width       = q.size32 ? asdt_pkg::ASDT_W_DWORD : asdt_pkg::ASDT_W_WORD;
      r.mem_op      = mem;
      r.clocks      = mul_clocks(mem, r.width, 1'b1, q.mul_extra);
      r.data_cycles = mem_cycles(mem, r.width);
      r.illegal     = 1'b0;
    end else if (q.opcode[7:1] == asdt_pkg::OPC_SH1_HI || q.opcode[7:1] == asdt_pkg::OPC_SHC_HI
                 || q.opcode[7:1] == asdt_pkg::OPC_SHI_HI) begin
      r.op_class    = asdt_pkg::ASDT_C_SHIFT;
      r.shift_kind  = fld; // [RULE_13]
      r.mem_op      = mem;
      r.data_cycles = mem ? asdt_pkg::DC_TWO : asdt_pkg::DC_NONE;
      r.illegal     = 1'b0;
      case (fld)
        asdt_pkg::SK_RCL, asdt_pkg::SK_RCR:
          r.clocks = rm_clocks(mem, asdt_pkg::CLK_RC_R, asdt_pkg::CLK_RC_M); // [RULE_15]
        asdt_pkg::SK_ROL, asdt_pkg::SK_ROR, asdt_pkg::SK_SHL, asdt_pkg::SK_SHR, asdt_pkg::SK_SAR:
          r.clocks = rm_clocks(mem, asdt_pkg::CLK_SH_R, asdt_pkg::CLK_SH_M); // [RULE_14]
        default: begin
          r.mem_op      = 1'b0;
          r.data_cycles = asdt_pkg::DC_NONE;
          r.illegal     = 1'b1;
        end
      endcase
    end else begin
      r.width   = asdt_pkg::ASDT_W_BYTE;
      r.illegal = 1'b0;
      case (q.opcode)
        asdt_pkg::OPC_AAA: begin
          r.op_class = asdt_pkg::ASDT_C_AAA;
          r.clocks   = asdt_pkg::CLK_FIX; // [RULE_04]
        end
        asdt_pkg::OPC_AAS: begin
          r.op_class = asdt_pkg::ASDT_C_AAS;
          r.clocks   = asdt_pkg::CLK_FIX; // [RULE_04]
        end
        asdt_pkg::OPC_DAA: begin
          r.op_class = asdt_pkg::ASDT_C_DAA;
          r.clocks   = asdt_pkg::CLK_FIX; // [RULE_04]
        end
        asdt_pkg::OPC_DAS: begin
          r.op_class = asdt_pkg::ASDT_C_DAS;
          r.clocks   = asdt_pkg::CLK_FIX; // [RULE_04]
        end
        asdt_pkg::OPC_CBW: begin
          r.op_class = asdt_pkg::ASDT_C_CBW;
          r.clocks   = asdt_pkg::CLK_CBW; // [RULE_12]
        end
        asdt_pkg::OPC_CWD: begin
          r.op_class = asdt_pkg::ASDT_C_CWD;
          r.clocks   = asdt_pkg::CLK_CWD; // [RULE_12]
        end
        asdt_pkg::OPC_AAD, asdt_pkg::OPC_AAM: begin
          // Second byte must be ten, other radix bytes are refused
          if (q.modrm == asdt_pkg::OPC_AAX_TAIL) begin
            r.op_class = (q.opcode == asdt_pkg::OPC_AAD) ? asdt_pkg::ASDT_C_AAD : asdt_pkg::ASDT_C_AAM; // [RULE_11]
            r.clocks   = (q.opcode == asdt_pkg::OPC_AAD) ? asdt_pkg::CLK_AAD : asdt_pkg::CLK_AAM; // [RULE_11]
          end else begin
            r.illegal = 1'b1;
          end
        end
        default: r.illegal = 1'b1;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.fsm)
      ASDT_S_IDLE: begin
        if (dec_valid_i) begin
          st_next.res   = decode(dec_in_i);
          st_next.count = st_next.res.clocks;
          st_next.fsm   = ASDT_S_EXEC;
          st_next.done  = (st_next.res.clocks == asdt_pkg::CLK_ILLEGAL);
          if (st_next.done)
            st_next.fsm = ASDT_S_IDLE;
        end
      end
      ASDT_S_EXEC: begin
        st_next.count = 6'(st_reg.count - 6'h01);
        // Done marks the final execution cycle, so busy spans exactly the clock count
        if (st_reg.count == 6'h02) begin
          st_next.done = 1'b1;
          st_next.fsm  = ASDT_S_IDLE;
        end
      end
      default: st_next.fsm = ASDT_S_IDLE;
    endcase
    st_next.busy = (st_next.fsm == ASDT_S_EXEC) || st_next.done;
    st_next.idle = !st_next.busy || st_next.done;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= '0;
      st_reg.fsm   <= ASDT_S_IDLE;
      st_reg.count <= asdt_pkg::COUNT_RST;
      st_reg.idle  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign idle_o    = st_reg.idle;
  assign busy_o    = st_reg.busy;
  assign done_o    = st_reg.done;
  assign dec_out_o = st_reg.res;

  logic [5:0] run_cnt_reg;
  logic       take;
  assign take = dec_valid_i && (st_reg.fsm == ASDT_S_IDLE);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i)
      run_cnt_reg <= 6'h00;
    else
      run_cnt_reg <= (busy_o && !done_o) ? 6'(run_cnt_reg + 6'h01) : 6'h00;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_run_length: assert property (done_o |-> run_cnt_reg == 6'(dec_out_o.clocks - 6'h01)) // [RULE_14]
    else $error("busy length differs from decoded clocks");
  a_cmp_imm_time: assert property (take && !dec_in_i.esc && dec_in_i.opcode[7:2] == asdt_pkg::OPC_GRP1_HI // [RULE_01]
      && dec_in_i.modrm[5:3] == asdt_pkg::FLD_CMP |=> dec_out_o.clocks == (dec_out_o.mem_op ? 6'h05 : 6'h02))
    else $error("compare immediate clock count wrong");
  a_cmp_acc_time: assert property (take && !dec_in_i.esc && dec_in_i.opcode[7:1] == asdt_pkg::OPC_CMPA_HI // [RULE_02]
      |=> busy_o ##1 done_o)
    else $error("short compare not done in two clocks");
  a_neg_mem_data: assert property (dec_out_o.op_class == asdt_pkg::ASDT_C_NEG && busy_o // [RULE_03]
      |-> dec_out_o.data_cycles == (dec_out_o.mem_op ? 2'h2 : 2'h0))
    else $error("sign change data cycles wrong");
  a_fix_four: assert property (take && !dec_in_i.esc && dec_in_i.opcode == asdt_pkg::OPC_DAA // [RULE_04]
      |=> (busy_o && !done_o) [*3] ##1 done_o)
    else $error("decimal fix not four clocks");
  a_mul_range: assert property (busy_o && dec_out_o.op_class inside {asdt_pkg::ASDT_C_MUL, // [RULE_05]
      asdt_pkg::ASDT_C_SIGNED_PRODUCT_ACC, asdt_pkg::ASDT_C_SIGNED_PRODUCT_REG} |-> dec_out_o.clocks >= 6'h0C && dec_out_o.clocks <= 6'h2E)
    else $error("product clocks outside range");
  a_imuli_word: assert property (busy_o && dec_out_o.op_class == asdt_pkg::ASDT_C_SIGNED_PRODUCT_IMM // [RULE_08]
      && dec_out_o.width == asdt_pkg::ASDT_W_WORD && !dec_out_o.mem_op |-> dec_out_o.clocks inside {[6'h0D:6'h1A]})
    else $error("immediate product word clocks wrong");
  a_div_dword: assert property (busy_o && dec_out_o.op_class == asdt_pkg::ASDT_C_SIGNED_QUOTIENT // [RULE_10]
      && dec_out_o.width == asdt_pkg::ASDT_W_DWORD |-> dec_out_o.clocks == (dec_out_o.mem_op ? 6'h30 : 6'h2B))
    else $error("signed quotient dword clocks wrong");
  a_rcl_time: assert property (busy_o && dec_out_o.op_class == asdt_pkg::ASDT_C_SHIFT // [RULE_15]
      && dec_out_o.shift_kind == 3'h2 |-> dec_out_o.clocks == (dec_out_o.mem_op ? 6'h0A : 6'h09))
    else $error("carry rotate clocks wrong");
  a_byte_width: assert property (take && !dec_in_i.esc && dec_in_i.opcode[7:1] == asdt_pkg::OPC_GRP3_HI // [RULE_18]
      && !dec_in_i.opcode[0] |=> dec_out_o.width == asdt_pkg::ASDT_W_BYTE)
    else $error("w bit clear did not give byte width");
  a_div_word: assert property (busy_o && dec_out_o.op_class == asdt_pkg::ASDT_C_DIV // [RULE_09]
      && dec_out_o.width == asdt_pkg::ASDT_W_WORD |-> dec_out_o.clocks == (dec_out_o.mem_op ? 6'h19 : 6'h16))
    else $error("unsigned quotient word clocks wrong");
  a_aad_time: assert property (take && !dec_in_i.esc && dec_in_i.opcode == asdt_pkg::OPC_AAD // [RULE_11]
      && dec_in_i.modrm == asdt_pkg::OPC_AAX_TAIL |=> dec_out_o.clocks == 6'h13)
    else $error("divide fix clocks wrong");
  a_cbw_time: assert property (take && !dec_in_i.esc && dec_in_i.opcode == asdt_pkg::OPC_CBW // [RULE_12]
      |=> (busy_o && !done_o) [*2] ##1 done_o)
    else $error("byte extend not three clocks");
  a_dsh_time: assert property (busy_o && (dec_out_o.op_class == asdt_pkg::ASDT_C_DOUBLE_SHIFT_LEFT // [RULE_16] [RULE_17]
      || dec_out_o.op_class == asdt_pkg::ASDT_C_DOUBLE_SHIFT_RIGHT) |-> dec_out_o.clocks == (dec_out_o.mem_op ? 6'h07 : 6'h03))
    else $error("double shift clocks wrong");
  a_shift_kind: assert property (take && !dec_in_i.esc && dec_in_i.opcode[7:1] == asdt_pkg::OPC_SH1_HI // [RULE_13]
      |=> dec_out_o.shift_kind == $past(dec_in_i.modrm[5:3]))
    else $error("shift kind not passed through");
  a_cmp_mem_data: assert property (busy_o && dec_out_o.op_class == asdt_pkg::ASDT_C_CMP_IMM // [RULE_01]
      |-> dec_out_o.data_cycles == (dec_out_o.mem_op ? 2'h1 : 2'h0))
    else $error("compare data cycles wrong");

  c_mul_mem: cover property (done_o && dec_out_o.op_class == asdt_pkg::ASDT_C_MUL && dec_out_o.mem_op);
  c_double_shift_left: cover property (done_o && dec_out_o.op_class == asdt_pkg::ASDT_C_DOUBLE_SHIFT_LEFT);
  c_aad: cover property (done_o && dec_out_o.op_class == asdt_pkg::ASDT_C_AAD);
  c_back_to_back: cover property (done_o ##1 busy_o);
  c_illegal: cover property (done_o && dec_out_o.illegal);

endmodule

// ---- testbench/asdt_fetch_model.sv ----
`timescale 1ns/1ps
// Instruction source: holds each request until the unit takes it, garbage otherwise
module asdt_fetch_model (
  input  wire logic                ref_clk_i,
  input  wire logic                idle_i,
  input  wire logic                go_i,
  input  wire asdt_pkg::asdt_req_t req_i,
  input  wire logic [1:0]          stall_i,
  output logic                     dec_valid_o,
  output asdt_pkg::asdt_req_t      dec_in_o,
  output int                       taken_o
);
  logic seen = 1'b0;
  int   wait_n = 0;
  int   sent = 0;
  initial begin
    dec_valid_o = 1'b0;
    dec_in_o = '0;
    taken_o = 0;
  end
  always @(posedge ref_clk_i) begin
    if (dec_valid_o && idle_i) taken_o <= taken_o + 1;
  end
  // Released lines toggle so a stale value can never pass for a request
  always @(negedge ref_clk_i) begin
    if (dec_valid_o && taken_o == sent) dec_valid_o <= 1'b0;
    if (!dec_valid_o && go_i != seen && wait_n < stall_i) wait_n <= wait_n + 1;
    else if (!dec_valid_o && go_i != seen) begin
      dec_valid_o <= 1'b1;
      dec_in_o <= req_i;
      seen <= go_i;
      sent <= sent + 1;
      wait_n <= 0;
    end else if (!dec_valid_o || taken_o == sent) dec_in_o <= ~dec_in_o;
  end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  logic                ref_clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                go = 1'b0;
  logic [1:0]          stall = 2'h0;
  asdt_pkg::asdt_req_t req = '0;
  logic                dec_valid;
  asdt_pkg::asdt_req_t dec_in;
  logic                idle_o;
  logic                busy_o;
  logic                done_o;
  asdt_pkg::asdt_res_t dec_out;
  int                  taken;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  logic [5:0]          nbusy = 6'h00;
  asdt_pkg::asdt_res_t exp_q [$];
  logic [5:0] lom [3] = '{6'h0F, 6'h0F, 6'h11};
  logic [5:0] imm [3] = '{6'h00, 6'h0E, 6'h10};
  logic [5:0] spn [3] = '{6'h05, 6'h0D, 6'h1D};
  logic [5:0] dvr [3] = '{6'h0E, 6'h16, 6'h26};
  logic [5:0] dvm [3] = '{6'h11, 6'h19, 6'h2B};
  logic [5:0] ivr [3] = '{6'h13, 6'h1B, 6'h2B};
  logic [5:0] ivm [3] = '{6'h16, 6'h1E, 6'h30};
  logic [1:0] dcm [3] = '{2'h1, 2'h1, 2'h2};
  logic [7:0] sh [6] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1};
  logic [7:0] fx [4] = '{8'h37, 8'h3F, 8'h27, 8'h2F};
  logic [7:0] dsh [4] = '{8'hA4, 8'hA5, 8'hAC, 8'hAD};
  always #4 ref_clk_i = ~ref_clk_i;
  asdt_core DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dec_valid_i(dec_valid), .dec_in_i(dec_in),
                 .idle_o(idle_o), .busy_o(busy_o), .done_o(done_o), .dec_out_o(dec_out));
  asdt_fetch_model u_fetch (.ref_clk_i(ref_clk_i), .idle_i(idle_o), .go_i(go), .req_i(req), .stall_i(stall),
                            .dec_valid_o(dec_valid), .dec_in_o(dec_in), .taken_o(taken));
  function automatic logic [5:0] mn(input logic [4:0] x, input logic [5:0] s);
    return ({1'b0, x} < s) ? {1'b0, x} : s;
  endfunction
  task automatic issue(input logic e, input logic [7:0] op, input logic [7:0] md, input logic s,
                       input logic [4:0] x, input logic [4:0] c, input logic [5:0] n, input logic [1:0] d);
    asdt_pkg::asdt_res_t r;
    int t0;
    r = '0;
    r.op_class = asdt_pkg::asdt_class_t'(c);
    r.clocks = n;
    r.data_cycles = d;
    r.illegal = (c == 5'h00);
    r.shift_kind = md[5:3];
    r.mem_op = (md[7:6] != 2'h3) && !(c inside {5'h0E, 5'h0F});
    if (c inside {[5'h04:5'h07], [5'h0E:5'h11]}) r.width = asdt_pkg::ASDT_W_BYTE;
    else if (e || c == 5'h0B || op[0]) r.width = s ? asdt_pkg::ASDT_W_DWORD : asdt_pkg::ASDT_W_WORD;
    else r.width = asdt_pkg::ASDT_W_BYTE;
    exp_q.push_back(r);
    @(negedge ref_clk_i);
    #1;
    req = '{e, op, md, s, x};
    stall = 2'($urandom_range(2, 0));
    go = ~go;
    t0 = taken;
    for (int i = 0; i < 200 && taken == t0; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Results are judged in the done cycle, when busy length and decode are final
  always @(negedge ref_clk_i) begin
    asdt_pkg::asdt_res_t ex;
    logic [20:0] m;
    if (!rst_i && busy_o === 1'b1) nbusy = nbusy + 6'h01;
    if (!rst_i && done_o === 1'b1) begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      m = ex.illegal ? 21'h0001F9 : (ex.op_class == 5'h12) ? 21'h1FFFFF : 21'h1FE3FF;
      `CHK(nbusy, ex.clocks)
      `CHK(idle_o, 1'b1)
      `CHK(dec_out & m, ex & m)
      nbusy = 6'h00;
    end
  end
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [4:0] x;
    logic [7:0] op;
    logic [7:0] md;
    logic [5:0] n;
    logic [1:0] d;
    logic       s;
    logic       mm;
    void'($urandom(32'h340dea89));
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rst_i = 1'b0;
    `CHK({idle_o, busy_o, done_o}, 3'h4)
    issue(0, 8'h83, 8'hF8, 1, 0, 5'h01, 6'h02, 2'h0);
    issue(0, 8'h80, 8'h38, 0, 0, 5'h01, 6'h05, 2'h1);
    issue(0, 8'h3C, 8'hC0, 0, 0, 5'h02, 6'h02, 2'h0);
    issue(0, 8'hF7, 8'hD8, 0, 0, 5'h03, 6'h02, 2'h0);
    issue(0, 8'hF6, 8'h18, 0, 0, 5'h03, 6'h06, 2'h2);
    foreach (fx[i]) issue(0, fx[i], 8'hC0, 0, 0, 5'(5'h04 + i), 6'h04, 2'h0);
    for (int w = 0; w < 3; w++) for (int k = 0; k < 2; k++) begin
      x = 5'($urandom_range(31, 0));
      op = (w == 0) ? 8'hF6 : 8'hF7;
      s = (w == 2);
      md = k ? 8'h00 : 8'hC0;
      n = (k ? lom[w] : 6'h0C) + mn(x, spn[w]);
      d = k ? dcm[w] : 2'h0;
      issue(0, op, md | 8'h20, s, x, 5'h08, n, d);
      issue(0, op, md | 8'h28, s, x, 5'h09, n, d);
      issue(0, op, md | 8'h30, s, x, 5'h0C, k ? dvm[w] : dvr[w], d);
      issue(0, op, md | 8'h38, s, x, 5'h0D, k ? ivm[w] : ivr[w], d);
      if (w > 0) begin
        issue(1, 8'hAF, md, s, x, 5'h0A, n, d);
        issue(0, 8'h6B, md, s, x, 5'h0B, (k ? imm[w] : 6'h0D) + mn(x, spn[w]), d);
      end
    end
    issue(0, 8'hD5, 8'h0A, 0, 0, 5'h0E, 6'h13, 2'h0);
    issue(0, 8'hD4, 8'h0A, 0, 0, 5'h0F, 6'h11, 2'h0);
    issue(0, 8'hD4, 8'h0B, 0, 0, 5'h00, 6'h01, 2'h0);
    issue(0, 8'h98, 8'hC0, 0, 0, 5'h10, 6'h03, 2'h0);
    issue(0, 8'h99, 8'hC0, 0, 0, 5'h11, 6'h02, 2'h0);
    foreach (sh[j]) for (int t = 0; t < 8; t++) begin
      mm = 1'($urandom_range(1, 0));
      md = {mm ? 2'h0 : 2'h3, 3'(t), 3'h0};
      n = (t == 2 || t == 3) ? (mm ? 6'h0A : 6'h09) : (mm ? 6'h07 : 6'h03);
      if (t == 6) issue(0, sh[j], md, 1, 0, 5'h00, 6'h01, 2'h0);
      else issue(0, sh[j], md, 1, 0, 5'h12, n, mm ? 2'h2 : 2'h0);
    end
    foreach (dsh[j]) for (int k = 0; k < 2; k++) begin
      issue(1, dsh[j], k ? 8'h00 : 8'hC0, 1, 0, dsh[j][3] ? 5'h14 : 5'h13,
            k ? 6'h07 : 6'h03, k ? 2'h2 : 2'h0);
    end
    repeat (60) @(posedge ref_clk_i);
    `CHK(exp_q.size(), 0)
    tally_and_finish();
  end
endmodule
